// File: hw/rxlo_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the receive output block
// Assumes: 32-bit APB data, byte addressing
// Notes: included by the package, the top module and the testbench
`ifndef RXLO_CONSTS_SVH
`define RXLO_CONSTS_SVH

`define RXLO_ADDR_W 12
`define RXLO_CTRL_OFS 12'h000
`define RXLO_STAT_OFS 12'h004
`define RXLO_IRQ_STAT_OFS 12'h008
`define RXLO_IRQ_MASK_OFS 12'h00C

`define RXLO_CTRL_SINGLE_RAIL_BIT 0
`define RXLO_CTRL_FALL_EDGE_BIT 1
`define RXLO_CTRL_RATE_LSB 2
`define RXLO_CTRL_RATE_MSB 4
`define RXLO_CTRL_RST 32'h0000_0004

`define RXLO_EV_LOS_BIT 0
`define RXLO_EV_LOL_BIT 1
`define RXLO_EV_CV_BIT 2
`define RXLO_EV_W 3
`define RXLO_MASK_RST 3'h0

`define RXLO_LOL_PPM 5000
`define RXLO_LOL_WINDOW 1024
`define RXLO_LOL_THRESH ((`RXLO_LOL_WINDOW * `RXLO_LOL_PPM + 999999) / 1000000)
`define RXLO_CNT_W 12

`endif

// File: hw/rxlo_pkg.sv
// Purpose: types shared by the receive output block
// Assumes: constants come from rxlo_consts.svh
// Notes: rate encoding is one-hot
`include "rxlo_consts.svh"

package rxlo_pkg;
    typedef enum logic [2:0] {
        RXLO_RATE_E3 = 3'b001,
        RXLO_RATE_DS3 = 3'b010,
        RXLO_RATE_SFM = 3'b100
    } rxlo_rate_type;

    typedef struct packed {
        rxlo_rate_type rate;
        logic fall_edge;
        logic single_rail;
    } rxlo_cfg_type;

    // asynchronous inputs, all passed through the synchroniser
    typedef struct packed {
        logic rclk;
        logic e3_ref;
        logic ds3_ref;
        logic sts1_ref;
        logic pos_pulse;
        logic neg_pulse;
        logic line_code_violation;
        logic excessive_zeros_event;
        logic loss_of_signal;
    } rxlo_line_type;

    typedef struct packed {
        logic [`RXLO_ADDR_W-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } rxlo_apb_req_type;
endpackage : rxlo_pkg

// File: hw/rxlo_top.sv
// Purpose: receive-side output stage of one line interface channel with APB control
// Assumes: pclk 25 MHz; line-side inputs are asynchronous and pass a 3-flop filter
// Notes: one APB wait state; interrupt status clears on read
// Operation
// - signal_loss_indicator is high exactly while loss of signal is declared.
// - lock_loss_indicator is high exactly while loss of lock is declared.
// - loss of lock is declared when the recovered clock is off its reference by 0.5% or more.
// - the reference is the E3 clock in E3 mode, DS3 clock in DS3 mode, synthesized STS-1 clock in SINGLE_FREQUENCY_MODE.
// - in dual-rail mode each positive line pulse gives one recovered period high on the positive output (code: not while the negative rail is also high).
// - in dual-rail mode negative pulses appear only on the negative output, never the positive one.
// - in single-rail mode the whole recovered data stream goes out on the positive/data output.
// - data outputs change only on the configured recovered clock edge, rising or falling.
// - in single-rail mode the negative pin flags code violations or excessive zeros for a period or more.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "rxlo_consts.svh"

module rxlo_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire rxlo_pkg::rxlo_apb_req_type apb_req,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic irq,
    input wire rxlo_pkg::rxlo_line_type line_in,
    output logic rx_positive_pulse_out,
    output logic rx_negative_pulse_out,
    output logic signal_loss_indicator,
    output logic lock_loss_indicator
);
    import rxlo_pkg::*;

    localparam int LW = $bits(rxlo_line_type);
    localparam int CW = `RXLO_CNT_W;
    localparam logic [CW-1:0] WINDOW = CW'(`RXLO_LOL_WINDOW);
    localparam logic [CW-1:0] THRESH = CW'(`RXLO_LOL_THRESH);
    localparam int CFGW = $bits(rxlo_cfg_type);

    function automatic logic [CW-1:0] abs_diff(input logic [CW-1:0] a, input logic [CW-1:0] b);
        abs_diff = (a > b) ? (a - b) : (b - a);
    endfunction : abs_diff

    function automatic logic is_addr(input logic [`RXLO_ADDR_W-1:0] a, input logic [`RXLO_ADDR_W-1:0] ofs);
        is_addr = (a == ofs);
    endfunction : is_addr

    // three-flop input filter
    logic [LW-1:0] sync1_ff, sync2_ff, sync3_ff, filt_ff, prev_ff;
    rxlo_line_type filt, prev;
    assign filt = rxlo_line_type'(filt_ff);
    assign prev = rxlo_line_type'(prev_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            filt_ff <= '0;
            prev_ff <= '0;
        end else begin
            sync1_ff <= line_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int i = 0; i < LW; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    filt_ff[i] <= sync3_ff[i];
                end
            end
            prev_ff <= filt_ff;
        end
    end

    // configuration and APB slave
    rxlo_cfg_type cfg_ff;
    logic [`RXLO_EV_W-1:0] ev_stat_ff, ev_mask_ff, ev_set;
    logic pready_ff, pslverr_ff, irq_ff;
    logic [31:0] prdata_ff;
    logic acc_done, stat_read, addr_ok;

    assign acc_done = apb_req.psel & apb_req.penable & pready_ff;
    assign addr_ok = is_addr(apb_req.paddr, `RXLO_CTRL_OFS) | is_addr(apb_req.paddr, `RXLO_STAT_OFS)
                   | is_addr(apb_req.paddr, `RXLO_IRQ_STAT_OFS) | is_addr(apb_req.paddr, `RXLO_IRQ_MASK_OFS);
    assign stat_read = acc_done & ~apb_req.pwrite & is_addr(apb_req.paddr, `RXLO_IRQ_STAT_OFS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= apb_req.psel & apb_req.penable & ~pready_ff;
            pslverr_ff <= apb_req.psel & apb_req.penable & ~pready_ff & ~addr_ok;
            prdata_ff <= 32'h0000_0000;
            if (apb_req.psel & apb_req.penable & ~pready_ff & ~apb_req.pwrite) begin
                case (1'b1)
                    is_addr(apb_req.paddr, `RXLO_CTRL_OFS): prdata_ff <= 32'(cfg_ff);
                    is_addr(apb_req.paddr, `RXLO_STAT_OFS): begin
                        prdata_ff <= 32'({lock_loss_indicator, signal_loss_indicator});
                    end
                    is_addr(apb_req.paddr, `RXLO_IRQ_STAT_OFS): prdata_ff <= 32'(ev_stat_ff | ev_set);
                    is_addr(apb_req.paddr, `RXLO_IRQ_MASK_OFS): prdata_ff <= 32'(ev_mask_ff);
                    default: prdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= rxlo_cfg_type'(CFGW'(`RXLO_CTRL_RST));
            ev_mask_ff <= `RXLO_MASK_RST;
        end else if (acc_done & apb_req.pwrite & ~pslverr_ff) begin
            if (is_addr(apb_req.paddr, `RXLO_CTRL_OFS)) begin
                cfg_ff.single_rail <= apb_req.pwdata[`RXLO_CTRL_SINGLE_RAIL_BIT];
                cfg_ff.fall_edge <= apb_req.pwdata[`RXLO_CTRL_FALL_EDGE_BIT];
                case (apb_req.pwdata[`RXLO_CTRL_RATE_MSB:`RXLO_CTRL_RATE_LSB])
                    3'h1: cfg_ff.rate <= RXLO_RATE_E3;
                    3'h2: cfg_ff.rate <= RXLO_RATE_DS3;
                    3'h4: cfg_ff.rate <= RXLO_RATE_SFM;
                    default: cfg_ff.rate <= cfg_ff.rate;
                endcase
            end
            if (is_addr(apb_req.paddr, `RXLO_IRQ_MASK_OFS)) begin
                ev_mask_ff <= apb_req.pwdata[`RXLO_EV_W-1:0];
            end
        end
    end

    logic los_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            los_ff <= 1'b0;
        end else begin
            los_ff <= filt.loss_of_signal;
        end
    end

    logic ref_now, ref_was, ref_edge, rclk_rise, rclk_fall, upd_edge;
    always_comb begin
        case (cfg_ff.rate)
            RXLO_RATE_E3: begin
                ref_now = filt.e3_ref;
                ref_was = prev.e3_ref;
            end
            RXLO_RATE_DS3: begin
                ref_now = filt.ds3_ref;
                ref_was = prev.ds3_ref;
            end
            default: begin
                ref_now = filt.sts1_ref;
                ref_was = prev.sts1_ref;
            end
        endcase
    end
    assign ref_edge = ref_now & ~ref_was;
    assign rclk_rise = filt.rclk & ~prev.rclk;
    assign rclk_fall = ~filt.rclk & prev.rclk;

    logic [CW-1:0] ref_cnt_ff, rclk_cnt_ff;
    logic lol_ff, win_end;
    assign win_end = ref_edge & (ref_cnt_ff == WINDOW - CW'(1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_cnt_ff <= '0;
            rclk_cnt_ff <= '0;
        end else if (win_end) begin
            ref_cnt_ff <= '0;
            rclk_cnt_ff <= '0;
        end else begin
            ref_cnt_ff <= ref_cnt_ff + CW'(ref_edge);
            if (rclk_rise && rclk_cnt_ff != '1) begin
                rclk_cnt_ff <= rclk_cnt_ff + CW'(1);
            end
        end
    end

    // lock released when back in range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lol_ff <= 1'b0;
        end else if (win_end) begin
            lol_ff <= abs_diff(rclk_cnt_ff + CW'(rclk_rise), WINDOW) >= THRESH;
        end
    end

    assign upd_edge = cfg_ff.fall_edge ? rclk_fall : rclk_rise;

    logic pos_ff, neg_ff, cv_hold_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_ff <= 1'b0;
            neg_ff <= 1'b0;
        end else if (upd_edge) begin
            if (cfg_ff.single_rail) begin
                pos_ff <= filt.pos_pulse | filt.neg_pulse;
                neg_ff <= cv_hold_ff | filt.line_code_violation | filt.excessive_zeros_event;
            end else begin
                // one period per pulse, rails kept apart
                pos_ff <= filt.pos_pulse & ~filt.neg_pulse;
                neg_ff <= filt.neg_pulse;
            end
        end
    end

    // short violation events between update edges are held until the next one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cv_hold_ff <= 1'b0;
        end else if (upd_edge) begin
            cv_hold_ff <= 1'b0;
        end else if (filt.line_code_violation | filt.excessive_zeros_event) begin
            cv_hold_ff <= 1'b1;
        end
    end

    // sticky events, set wins over read clear
    assign ev_set[`RXLO_EV_LOS_BIT] = filt.loss_of_signal & ~los_ff;
    assign ev_set[`RXLO_EV_LOL_BIT] = win_end & ~lol_ff & (abs_diff(rclk_cnt_ff + CW'(rclk_rise), WINDOW) >= THRESH);
    assign ev_set[`RXLO_EV_CV_BIT] = cfg_ff.single_rail & upd_edge
                                   & (cv_hold_ff | filt.line_code_violation | filt.excessive_zeros_event);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_stat_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            ev_stat_ff <= (stat_read ? '0 : ev_stat_ff) | ev_set;
            irq_ff <= |(((stat_read ? '0 : ev_stat_ff) | ev_set) & ev_mask_ff);
        end
    end

    assign pready = pready_ff;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign rx_positive_pulse_out = pos_ff;
    assign rx_negative_pulse_out = neg_ff;
    assign signal_loss_indicator = los_ff;
    assign lock_loss_indicator = lol_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    los_follow_a: assert property (signal_loss_indicator == $past(filt.loss_of_signal))
        else $error("loss of signal indicator does not follow defect");
    lol_hold_a: assert property (!win_end |=> $stable(lock_loss_indicator))
        else $error("lock indicator moved outside window end");
    lol_declare_a: assert property (win_end && abs_diff(rclk_cnt_ff + CW'(rclk_rise), WINDOW) >= THRESH
        |=> lock_loss_indicator) else $error("loss of lock not declared");
    lol_release_a: assert property (win_end && abs_diff(rclk_cnt_ff + CW'(rclk_rise), WINDOW) < THRESH
        |=> !lock_loss_indicator) else $error("loss of lock not released");
    ref_select_a: assert property (cfg_ff.rate == RXLO_RATE_DS3 |-> ref_now == filt.ds3_ref)
        else $error("wrong reference clock selected");
    dual_pos_a: assert property (upd_edge && !cfg_ff.single_rail && filt.pos_pulse && !filt.neg_pulse
        |=> rx_positive_pulse_out) else $error("positive pulse missing");
    dual_neg_a: assert property (upd_edge && !cfg_ff.single_rail && filt.neg_pulse
        |=> rx_negative_pulse_out && !rx_positive_pulse_out) else $error("negative pulse on wrong rail");
    single_data_a: assert property (upd_edge && cfg_ff.single_rail
        |=> rx_positive_pulse_out == $past(filt.pos_pulse | filt.neg_pulse)) else $error("single rail data lost");
    edge_only_a: assert property (!upd_edge |=> $stable(rx_positive_pulse_out) && $stable(rx_negative_pulse_out))
        else $error("data changed off the update edge");
    cv_flag_a: assert property (cfg_ff.single_rail && upd_edge && filt.line_code_violation
        |=> rx_negative_pulse_out) else $error("code violation not flagged");

    // bus handshake
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_after_access_a: assert property (apb_req.psel && apb_req.penable && !pready |=> pready)
        else $error("ready not given after access cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error response without ready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero outside ready");

    // interrupt status
    irq_level_a: assert property (irq == |(ev_stat_ff & $past(ev_mask_ff)))
        else $error("interrupt level does not match masked status");
    stat_sticky_a: assert property (|ev_set
        |=> (ev_stat_ff & $past(ev_set)) == $past(ev_set)) else $error("event not kept in status");
    los_event_a: assert property ($rose(signal_loss_indicator) |-> ev_stat_ff[`RXLO_EV_LOS_BIT])
        else $error("signal loss event not recorded");
    lol_event_a: assert property ($rose(lock_loss_indicator) |-> ev_stat_ff[`RXLO_EV_LOL_BIT])
        else $error("lock loss event not recorded");

    // configuration
    rate_onehot_a: assert property ($onehot(cfg_ff.rate))
        else $error("rate selection not one-hot");

    dual_pulse_c: cover property (upd_edge && !cfg_ff.single_rail && filt.pos_pulse ##1 rx_positive_pulse_out);
    single_cv_c: cover property (cfg_ff.single_rail && rx_negative_pulse_out);
    lol_set_c: cover property (!lock_loss_indicator ##1 lock_loss_indicator);
    irq_c: cover property (irq ##[1:20] stat_read);
    stat_clear_c: cover property (stat_read ##1 ev_stat_ff == '0);
endmodule : rxlo_top

// File: test/rxlo_framer_model.sv
// Purpose: downstream framer that samples the receive data outputs
// Assumes: recovered clock and update edge selection come from the bench
// Notes: keeps a short history of both outputs for comparison
`timescale 1ns/1ps

module rxlo_framer_model (
    input wire logic rclk,
    input wire logic fall_edge,
    input wire logic rx_positive_pulse_out,
    input wire logic rx_negative_pulse_out,
    output logic [15:0] pos_hist,
    output logic [15:0] neg_hist
);
    initial begin
        pos_hist = 16'h0000;
        neg_hist = 16'h0000;
    end

    always @(posedge rclk or negedge rclk) begin
        if (rclk === fall_edge) begin
            pos_hist <= {pos_hist[14:0], rx_positive_pulse_out};
            neg_hist <= {neg_hist[14:0], rx_negative_pulse_out};
        end
    end
endmodule : rxlo_framer_model

// File: test/test_rxlo_top.sv
// Purpose: self-checking bench of the receive output block
// Assumes: pclk 40 ns; line clocks are made from pclk counters
// Notes: loss-of-lock windows make the run some 51k cycles long
`timescale 1ns/1ps
`include "rxlo_consts.svh"

module test_rxlo_top;
    import rxlo_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    rxlo_apb_req_type apb_req = '0;
    rxlo_line_type line_in = '0;
    logic pready, pslverr, irq;
    logic [31:0] prdata;
    logic rx_positive_pulse_out, rx_negative_pulse_out, signal_loss_indicator, lock_loss_indicator;
    logic [15:0] pos_hist, neg_hist;
    logic fall_edge = 1'b0;
    logic [31:0] rd;
    logic err;
    int rc = 0, ec = 0, dc = 3, sc = 0;
    int fail_count = 0;
    int comparisons = 0;

    always #20 pclk = ~pclk;

    rxlo_top dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq(irq), .line_in(line_in), .rx_positive_pulse_out(rx_positive_pulse_out),
        .rx_negative_pulse_out(rx_negative_pulse_out), .signal_loss_indicator(signal_loss_indicator),
        .lock_loss_indicator(lock_loss_indicator));

    rxlo_framer_model framer (.rclk(line_in.rclk), .fall_edge(fall_edge),
        .rx_positive_pulse_out(rx_positive_pulse_out), .rx_negative_pulse_out(rx_negative_pulse_out),
        .pos_hist(pos_hist), .neg_hist(neg_hist));

    // recovered clock 16 pclk, e3 17, ds3 16, sts1 17
    always @(posedge pclk) begin
        rc <= (rc + 1) % 16;
        ec <= (ec + 1) % 17;
        dc <= (dc + 1) % 16;
        sc <= (sc + 1) % 17;
        line_in.rclk <= rc < 8;
        line_in.e3_ref <= ec < 8;
        line_in.ds3_ref <= dc < 8;
        line_in.sts1_ref <= sc < 8;
    end

    task automatic summarize();
        $display("compared %0d failed %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        int k;
        @(posedge pclk);
        apb_req <= '{paddr: addr, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wdata};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        if (k == 16) begin
            fail_count++;
            summarize();
        end
    endtask : apb

    task automatic wait_for(input logic lock, input logic v, input int bound);
        int k;
        for (k = 0; k < bound; k++) begin
            @(posedge pclk);
            if ((lock ? lock_loss_indicator : signal_loss_indicator) === v) break;
        end
        if (k == bound) begin
            fail_count++;
            summarize();
        end
    endtask : wait_for

    // bits go out msb first, away from the update edge, then one idle bit
    task automatic send(input logic [7:0] p, input logic [7:0] n, input logic [7:0] cv, input logic [7:0] ez);
        int i;
        int w;
        for (i = 0; i <= 8; i++) begin
            for (w = 0; w < 32; w++) begin
                @(posedge pclk);
                if (rc == (fall_edge ? 2 : 10)) break;
            end
            if (w == 32) begin
                fail_count++;
                summarize();
            end
            line_in.pos_pulse <= p[7];
            line_in.neg_pulse <= n[7];
            line_in.line_code_violation <= cv[7];
            line_in.excessive_zeros_event <= ez[7];
            p = p << 1;
            n = n << 1;
            cv = cv << 1;
            ez = ez << 1;
        end
    endtask : send

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `RXLO_CTRL_OFS, 32'h0);
        check("ctrl reset", rd, `RXLO_CTRL_RST);
        apb(1'b0, `RXLO_IRQ_MASK_OFS, 32'h0);
        check("mask reset", rd, 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        check("unmapped err", err, 32'h1);
        check("unmapped data", rd, 32'h0);
        line_in.loss_of_signal <= 1'b1;
        wait_for(1'b0, 1'b1, 20);
        check("los set", signal_loss_indicator, 32'h1);
        apb(1'b0, `RXLO_STAT_OFS, 32'h0);
        check("status los", rd & 32'h1, 32'h1);
        check("irq masked", irq, 32'h0);
        apb(1'b1, `RXLO_IRQ_MASK_OFS, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq raised", irq, 32'h1);
        apb(1'b0, `RXLO_IRQ_STAT_OFS, 32'h0);
        check("irq status", rd, 32'h1);
        apb(1'b0, `RXLO_IRQ_STAT_OFS, 32'h0);
        check("irq cleared", rd, 32'h0);
        check("irq low", irq, 32'h0);
        line_in.loss_of_signal <= 1'b0;
        wait_for(1'b0, 1'b0, 20);
        check("los clear", signal_loss_indicator, 32'h0);
        // both rails high on the last bit counts as negative only
        apb(1'b1, `RXLO_CTRL_OFS, 32'h4);
        send(8'hC3, 8'h29, 8'h00, 8'h00);
        check("pos rise", pos_hist[7:0], 8'hC2);
        check("neg rise", neg_hist[7:0], 8'h29);
        fall_edge <= 1'b1;
        apb(1'b1, `RXLO_CTRL_OFS, 32'h6);
        send(8'hA5, 8'h42, 8'h00, 8'h00);
        check("pos fall", pos_hist[7:0], 8'hA5);
        check("neg fall", neg_hist[7:0], 8'h42);
        fall_edge <= 1'b0;
        apb(1'b1, `RXLO_CTRL_OFS, 32'h5);
        send(8'h90, 8'h05, 8'h00, 8'h00);
        check("single data", pos_hist[7:0], 8'h95);
        check("no flag", neg_hist[7:0], 8'h00);
        send(8'h00, 8'h00, 8'h10, 8'h00);
        check("cv flag", |neg_hist[7:0], 32'h1);
        send(8'h00, 8'h00, 8'h00, 8'h08);
        check("exz flag", |neg_hist[7:0], 32'h1);
        apb(1'b0, `RXLO_IRQ_STAT_OFS, 32'h0);
        check("irq cv", rd, 32'h4);
        apb(1'b1, `RXLO_CTRL_OFS, 32'h4);
        wait_for(1'b1, 1'b1, 45000);
        check("lol e3", lock_loss_indicator, 32'h1);
        apb(1'b0, `RXLO_STAT_OFS, 32'h0);
        check("status lol", rd & 32'h2, 32'h2);
        apb(1'b0, `RXLO_IRQ_STAT_OFS, 32'h0);
        check("irq lol", rd & 32'h2, 32'h2);
        apb(1'b1, `RXLO_CTRL_OFS, 32'h8);
        wait_for(1'b1, 1'b0, 40000);
        check("lol ds3", lock_loss_indicator, 32'h0);
        apb(1'b1, `RXLO_CTRL_OFS, 32'h10);
        wait_for(1'b1, 1'b1, 45000);
        check("lol sfm", lock_loss_indicator, 32'h1);
        apb(1'b1, `RXLO_CTRL_OFS, 32'h1C);
        apb(1'b0, `RXLO_CTRL_OFS, 32'h0);
        check("bad rate kept", rd, 32'h10);
        summarize();
    end
endmodule : test_rxlo_top
